// >>> include/dss_pkg.sv
// Package for the soft single request and source address block.
// Assumes one 20 MHz core clock and a plain strobe register port.
package dss_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_SOFT_SREQ = 8'h00;
	localparam logic [7:0] ADDR_CTRL_CFG = 8'h04;
	localparam logic [7:0] ADDR_CH_SRC = 8'h08;
	localparam logic [7:0] ADDR_CH_SETUP = 8'h0c;
	localparam logic [7:0] ADDR_CH_CTRL = 8'h10;
	localparam logic [7:0] ADDR_CH_STEP = 8'h14;

	localparam int NUM_REQ = 16;
	localparam int CFG_RUN_BIT = 0;
	localparam int SETUP_EN_BIT = 0;
	localparam int CTRL_SWIDTH_LSB = 18;
	localparam int CTRL_SWIDTH_MSB = 20;
	localparam logic [31:0] SRC_RESET = 32'h00000000;
	localparam logic [31:0] READ_NONE = 32'h00000000;

	localparam logic [2:0] WIDTH_BYTE = 3'h0;
	localparam logic [2:0] WIDTH_HALF = 3'h1;
	localparam logic [2:0] WIDTH_WORD = 3'h2;

	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 32;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_PUSH = 3'b100
	} dss_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dss_bus_req_t;

endpackage

// >>> src/dss_fifo.sv
// Synchronous FIFO that buffers source words fetched by the channel.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module dss_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} dss_fifo_st_t;

	dss_fifo_st_t st_q;
	dss_fifo_st_t st_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	assign o_in_ready = (st_q.cnt != (AW+1)'(DEPTH));
	assign o_out_valid = (st_q.cnt != '0);
	assign o_out_data = mem[st_q.rp];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.wp = (st_q.wp == AW'(DEPTH - 1)) ? '0 : st_q.wp + 1'b1;
		end
		if (pop) begin
			st_d.rp = (st_q.rp == AW'(DEPTH - 1)) ? '0 : st_q.rp + 1'b1;
		end
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[st_q.wp] <= i_in_data;
		end
	end
endmodule // dss_fifo
`default_nettype wire

// >>> src/dss_top.sv
// Soft single request, controller run bit and one channel source address.
// Assumes a strobe register port and a simple request/ack fetch bus that may take any number of cycles to ack.
`timescale 1ns/1ns
`default_nettype none
module dss_top
	import dss_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	input wire logic [NUM_REQ-1:0] I_HW_SREQ,
	output logic O_FETCH_REQ,
	output logic [31:0] O_FETCH_ADDR,
	input wire logic I_FETCH_ACK,
	input wire logic [31:0] I_FETCH_DATA,
	output logic O_DATA_VALID,
	output logic [31:0] O_DATA,
	input wire logic I_DATA_READY,
	output logic O_BUSY
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic run;
		logic ch_en;
		logic [2:0] swidth;
		logic [31:0] src;
		logic [31:0] src_work;
		logic [NUM_REQ-1:0] active;
		logic [3:0] cur;
		dss_state_t fsm;
		logic [31:0] word;
		logic [31:0] rdata;
		logic fetch_req;
		logic [31:0] out_data;
		logic out_valid;
		logic busy;
	} dss_top_st_t;

	dss_top_st_t st_q;
	dss_top_st_t st_d;
	dss_bus_req_t bus;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [31:0] fifo_out_data;
	logic pick_found;
	logic [3:0] pick_idx;
	logic [31:0] step;
	logic out_take;

	assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
	// Output stage registered so every top output comes from a flip-flop.
	assign out_take = !st_q.out_valid || I_DATA_READY;

	dss_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_in_valid(st_q.fsm == ST_PUSH),
		.o_in_ready(fifo_in_ready),
		.i_in_data(st_q.word),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(out_take),
		.o_out_data(fifo_out_data)
	);

	// ----------------------------------------------------------------
	// Request pick and address step
	// ----------------------------------------------------------------
	always_comb begin
		pick_found = 1'b0;
		pick_idx = 4'h0;
		for (int i = NUM_REQ - 1; i >= 0; i--) begin
			if (st_q.active[i]) begin
				pick_found = 1'b1;
				pick_idx = 4'(i);
			end
		end
	end

	always_comb begin
		unique case (st_q.swidth)
			WIDTH_HALF: step = 32'h00000002;
			WIDTH_WORD: step = 32'h00000004;
			default: step = 32'h00000001;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.rdata = READ_NONE;
		if (bus.wr && bus.addr == ADDR_CTRL_CFG) begin
			st_d.run = bus.wdata[CFG_RUN_BIT];
		end
		if (bus.rd && bus.addr == ADDR_CTRL_CFG) begin
			st_d.rdata = {31'h00000000, st_q.run};
		end
		if (st_q.run) begin
			if (bus.wr) begin
				unique case (bus.addr)
					ADDR_CH_SRC: st_d.src = bus.wdata;
					ADDR_CH_SETUP: begin
						st_d.ch_en = bus.wdata[SETUP_EN_BIT];
						if (bus.wdata[SETUP_EN_BIT] && !st_q.ch_en) begin
							st_d.src_work = st_q.src;
						end
					end
					ADDR_CH_CTRL: st_d.swidth = bus.wdata[CTRL_SWIDTH_MSB:CTRL_SWIDTH_LSB];
					default: ;
				endcase
			end
			if (bus.rd) begin
				unique case (bus.addr)
					ADDR_SOFT_SREQ: st_d.rdata = {16'h0000, st_q.active};
					// While enabled the live pointer is shown, so reads move.
					ADDR_CH_SRC: st_d.rdata = st_q.ch_en ? st_q.src_work : st_q.src;
					ADDR_CH_SETUP: st_d.rdata = {31'h00000000, st_q.ch_en};
					ADDR_CH_CTRL: st_d.rdata = {11'h000, st_q.swidth, 18'h00000};
					ADDR_CH_STEP: st_d.rdata = step;
					default: ;
				endcase
			end
		end

		unique case (st_q.fsm)
			ST_IDLE: begin
				if (st_q.run && st_q.ch_en && pick_found) begin
					st_d.cur = pick_idx;
					st_d.fsm = ST_READ;
					st_d.fetch_req = 1'b1;
				end
			end
			ST_READ: begin
				if (I_FETCH_ACK) begin
					st_d.word = I_FETCH_DATA;
					st_d.fetch_req = 1'b0;
					st_d.fsm = ST_PUSH;
				end
			end
			ST_PUSH: begin
				if (fifo_in_ready) begin
					st_d.src_work = st_q.src_work + step;
					st_d.active[st_q.cur] = 1'b0;
					st_d.fsm = ST_IDLE;
				end
			end
		endcase

		// A new trigger outranks the completion clear of the same bit.
		if (st_q.run && bus.wr && bus.addr == ADDR_SOFT_SREQ) begin
			st_d.active = st_d.active | bus.wdata[NUM_REQ-1:0];
		end
		// Hardware requests share the tracker; software and hardware triggers set the same active bits.
		if (st_q.run) begin
			st_d.active = st_d.active | I_HW_SREQ;
		end
		if (!st_q.run) begin
			st_d.active = '0;
		end

		if (out_take) begin
			st_d.out_valid = fifo_out_valid;
			st_d.out_data = fifo_out_data;
		end
		st_d.busy = (st_d.fsm != ST_IDLE);
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			st_q <= '{run: 1'b0, ch_en: 1'b0, swidth: WIDTH_BYTE, src: SRC_RESET,
				src_work: SRC_RESET, active: '0, cur: 4'h0, fsm: ST_IDLE,
				word: 32'h00000000, rdata: READ_NONE, fetch_req: 1'b0,
				out_data: 32'h00000000, out_valid: 1'b0, busy: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign O_RDATA = st_q.rdata;
	assign O_FETCH_REQ = st_q.fetch_req;
	assign O_FETCH_ADDR = st_q.src_work;
	assign O_DATA_VALID = st_q.out_valid;
	assign O_DATA = st_q.out_data;
	assign O_BUSY = st_q.busy;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);

	AST_TRIGGER: assert property (st_q.run && I_WR && I_ADDR == ADDR_SOFT_SREQ && I_WDATA[3]
		|=> st_q.active[3]) else $error("soft trigger not taken");
	AST_READBACK: assert property (st_q.run && I_RD && I_ADDR == ADDR_SOFT_SREQ
		|=> O_RDATA == {16'h0000, $past(st_q.active)}) else $error("bad readback");
	AST_STOPPED: assert property (!st_q.run |=> st_q.active == '0)
		else $error("active while stopped");
	AST_LOCKED: assert property (!st_q.run && I_WR && I_ADDR == ADDR_CH_SRC
		|=> $stable(st_q.src)) else $error("write while stopped");
	AST_SRCWR: assert property (st_q.run && I_WR && I_ADDR == ADDR_CH_SRC
		|=> st_q.src == $past(I_WDATA)) else $error("source not stored");
	AST_LOAD: assert property (st_q.run && !st_q.ch_en && I_WR && I_ADDR == ADDR_CH_SETUP
		&& I_WDATA[0] |=> st_q.src_work == $past(st_q.src)) else $error("no load");
	AST_STEP: assert property (st_q.fsm == ST_PUSH && fifo_in_ready
		|=> st_q.src_work == $past(st_q.src_work) + $past(step)) else $error("no step");
	AST_DONE: assert property (st_q.fsm == ST_PUSH && fifo_in_ready && !I_HW_SREQ[st_q.cur]
		&& !(I_WR && I_ADDR == ADDR_SOFT_SREQ) |=> !st_q.active[$past(st_q.cur)])
		else $error("running bit stuck");
	AST_NOREAD: assert property (!st_q.run && I_RD && I_ADDR == ADDR_CH_SRC
		|=> O_RDATA == READ_NONE) else $error("read while stopped");

	COV_XFER: cover property (st_q.fsm == ST_READ ##[1:10] st_q.fsm == ST_PUSH);
	COV_FULL: cover property (!fifo_in_ready);
	COV_OUT: cover property (O_DATA_VALID && I_DATA_READY);
endmodule // dss_top
`default_nettype wire

// >>> tb/dss_mem_model.sv
// Fetch-side memory model for the soft single request block.
// Assumes the registered request level held until one ack pulse.
`timescale 1ns/1ns
`default_nettype none
module dss_mem_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_req,
	input wire logic [31:0] i_addr,
	input wire logic i_slow,
	output logic o_ack,
	output logic [31:0] o_data
);
	logic [2:0] cnt_q;

	// Data is only meaningful with the ack; otherwise it toggles, or holds while a slow request counts, so stale values never match.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_ack <= 1'b0;
			cnt_q <= 3'h0;
			o_data <= 32'h00000000;
		end else if (o_ack) begin
			o_ack <= 1'b0;
			cnt_q <= 3'h0;
			o_data <= ~o_data;
		end else if (i_req && (!i_slow || cnt_q == 3'h5)) begin
			o_ack <= 1'b1;
			o_data <= i_addr ^ 32'h3c3c0000;
		end else if (i_req) begin
			cnt_q <= cnt_q + 3'h1;
		end else begin
			o_data <= ~o_data;
		end
	end
endmodule // dss_mem_model
`default_nettype wire

// >>> tb/dss_top_tb.sv
// Self-checking bench for the soft single request and source address block.
// Assumes the strobe register port and the fetch memory model beside it.
`timescale 1ns/1ns
`default_nettype none
module dss_top_tb;
	import dss_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ready = 1'b0, slow = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata, faddr, fdata, odata, got, base;
	logic freq, ack, oval, busy;
	logic [31:0] bases [10];
	int n_errors = 0, samples_checked = 0, i, w, r, k, n;

	always #25 clk = ~clk;

	dss_top u_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_HW_SREQ(16'h0000),
		.O_FETCH_REQ(freq), .O_FETCH_ADDR(faddr), .I_FETCH_ACK(ack), .I_FETCH_DATA(fdata),
		.O_DATA_VALID(oval), .O_DATA(odata), .I_DATA_READY(ready), .O_BUSY(busy));
	dss_mem_model u_mem (.i_clk(clk), .i_rst_n(rst_n), .i_req(freq), .i_addr(faddr),
		.i_slow(slow), .o_ack(ack), .o_data(fdata));

	// ----------------------------------------------------------------
	// Bus tasks and checking
	// ----------------------------------------------------------------
	task automatic write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just after that edge.
	task automatic read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic poll(input logic [31:0] exp);
		for (n = 0; n < 40; n++) begin
			read(ADDR_SOFT_SREQ, got);
			if (got === exp) break;
		end
	endtask

	task automatic conclude;
		$display("errors %0d, comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (8000) @(posedge clk);
		n_errors++;
		conclude();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		read(ADDR_CTRL_CFG, got);
		check(got, 32'h00000000);
		write(ADDR_CH_SRC, 32'h12345678);
		read(ADDR_CH_SRC, got);
		check(got, READ_NONE);
		write(ADDR_CTRL_CFG, 32'h00000001);
		read(ADDR_CH_SRC, got);
		check(got, SRC_RESET);
		write(ADDR_CH_SRC, 32'hfedcba98);
		read(ADDR_CH_SRC, got);
		check(got, 32'hfedcba98);
		read(8'hfc, got);
		check(got, 32'h00000000);
		write(ADDR_SOFT_SREQ, 32'h00000000);
		read(ADDR_SOFT_SREQ, got);
		check(got, 32'h00000000);
		// The stream side stalls: the output stage takes one word and the buffer eight more,
		// so the tenth transfer is held back in the push state.
		for (i = 0; i < 10; i++) begin
			w = i % 3;
			r = (i * 7) % 16;
			base = 32'h20000100 + 32'(i) * 32'h10 + ((w == 0) ? 32'h3 : 32'h0);
			bases[i] = base;
			slow <= i[0];
			write(ADDR_CH_SETUP, 32'h00000000);
			write(ADDR_CH_SRC, base);
			write(ADDR_CH_CTRL, 32'(w) << CTRL_SWIDTH_LSB);
			write(ADDR_CH_SETUP, 32'h00000001);
			write(ADDR_SOFT_SREQ, 32'h1 << r);
			read(ADDR_SOFT_SREQ, got);
			check(got, 32'h1 << r);
			if (i < 9) begin
				poll(32'h00000000);
				check(got, 32'h00000000);
				read(ADDR_CH_SRC, got);
				check(got, base + (32'h1 << w));
			end else begin
				repeat (30) @(posedge clk);
				read(ADDR_SOFT_SREQ, got);
				check(got, 32'h1 << r);
				check({31'h0, busy}, 32'h1);
			end
		end
		@(posedge clk);
		ready <= 1'b1;
		#1;
		for (k = 0; k < 10; k++) begin
			for (n = 0; n < 40 && oval !== 1'b1; n++) begin
				@(posedge clk);
				#1;
			end
			check(odata, bases[k] ^ 32'h3c3c0000);
			@(posedge clk);
			#1;
		end
		poll(32'h00000000);
		check(got, 32'h00000000);
		check({31'h0, busy}, 32'h0);
		write(ADDR_CTRL_CFG, 32'h00000000);
		read(ADDR_CH_SRC, got);
		check(got, READ_NONE);
		conclude();
	end
endmodule // dss_top_tb
`default_nettype wire
